// *** src/pss_pkg.sv ***
// Package of constants and types for the pipelined SRAM strobe/data port
// Behaviour
// - Processor strobe low captures address, loads counter
// - Controller strobe low captures address, loads counter
// - Controller capture preloads counter from low bits
// - Both strobes low: processor strobe wins
// - Processor strobe ignored while primary select high
// - Captured address governs the following access
// - Sleep input quiets device, memory kept
// - Sleep held low or floating means awake
// - Write data registered on rising edge
// - Read data appears one clock after capture
// - Data lines driven only while enable low
// - Enable high leaves data lines released
// - New address needs all three selects active
// - Step low advances two-bit burst counter
// - First read after deselect masks output enable
// - Strap low linear, high interleaved burst order
package pss_pkg;

  // ==========================================================
  // Widths and reset values
  localparam int          PSS_ADDR_W   = 18;
  localparam int          PSS_DATA_W   = 32;
  localparam int          PSS_PAR_W    = 4;
  localparam int          PSS_BURST_W  = 2;
  localparam logic [1:0]  PSS_STEP_RST = 2'h0;
  localparam logic        PSS_BIT_RST  = 1'h0;
  localparam logic        PSS_OE_N_RST = 1'h1;

  // ==========================================================
  // Synchronous control pins sampled together
  typedef struct packed {
    logic proc_strobe_n;
    logic ctrl_strobe_n;
    logic primary_select_n;
    logic secondary_select;
    logic tertiary_select_n;
    logic burst_step_n;
    logic write_n;
  } pss_ctl_t;

endpackage

// *** src/pss_sram_port.sv ***
// Pipelined synchronous burst SRAM: strobes, burst counter, data port
`timescale 1ns/1ns
module pss_sram_port #(
  parameter int ADDR_W = pss_pkg::PSS_ADDR_W,
  parameter int DATA_W = pss_pkg::PSS_DATA_W,
  parameter int PAR_W  = pss_pkg::PSS_PAR_W
) (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  // Address and control
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire pss_pkg::pss_ctl_t ctl_in,
  input  wire logic              burst_order_in,
  // Asynchronous controls
  input  wire logic              output_enable_n_in,
  input  wire logic              sleep_request_in,
  // Data and parity pins
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic [PAR_W-1:0]  parity_io_in,
  output logic      [DATA_W-1:0] data_out,
  output logic      [PAR_W-1:0]  parity_io_out,
  output logic                   data_oe_n_out
);

  localparam int BW = pss_pkg::PSS_BURST_W;
  localparam int WW = DATA_W + PAR_W;

  // Refuse widths the address split cannot serve
  if (ADDR_W <= BW || DATA_W < 1 || PAR_W < 1) begin : g_bad_width
    $error("pss_sram_port: unsupported width parameters");
  end

  // ==========================================================
  // Storage
  logic [WW-1:0] mem [0:(1<<ADDR_W)-1];

  // ==========================================================
  // Synchronisers for sleep and output enable
  logic sleep_s1_r, sleep_s2_r, oe_s1_r, oe_s2_r;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sleep_s1_r <= pss_pkg::PSS_BIT_RST;
      sleep_s2_r <= pss_pkg::PSS_BIT_RST;
      oe_s1_r    <= pss_pkg::PSS_OE_N_RST;
      oe_s2_r    <= pss_pkg::PSS_OE_N_RST;
    end else begin
      sleep_s1_r <= sleep_request_in;
      sleep_s2_r <= sleep_s1_r;
      oe_s1_r <= output_enable_n_in;
      oe_s2_r <= oe_s1_r;
    end
  end

  // ==========================================================
  // Address capture and burst state
  logic [ADDR_W-1:BW] addr_hi_r, addr_hi_nxt;
  logic [BW-1:0]      start_r, start_nxt, step_r, step_nxt;
  logic               active_r, active_nxt, mask_r, mask_nxt;
  logic               sel_all, cap_p, cap_c, cap_any, strobe_seen, awake;
  logic [BW-1:0]      low_addr;
  logic [ADDR_W-1:0]  cur_addr;

  always_comb begin
    awake       = !sleep_s2_r;
    sel_all     = !ctl_in.primary_select_n && ctl_in.secondary_select &&
                  !ctl_in.tertiary_select_n;
    cap_p       = awake && !ctl_in.proc_strobe_n &&
                  !ctl_in.primary_select_n && sel_all;
    cap_c       = awake && !ctl_in.ctrl_strobe_n && sel_all &&
                  (ctl_in.proc_strobe_n || ctl_in.primary_select_n);
    cap_any     = cap_p || cap_c;
    strobe_seen = (!ctl_in.proc_strobe_n && !ctl_in.primary_select_n) ||
                  !ctl_in.ctrl_strobe_n;
    low_addr    = burst_order_in ? (start_r ^ step_r)
                                 : BW'(start_r + step_r);
    cur_addr    = {addr_hi_r, low_addr};
    addr_hi_nxt = addr_hi_r;
    start_nxt   = start_r;
    step_nxt    = step_r;
    active_nxt  = active_r;
    mask_nxt    = pss_pkg::PSS_BIT_RST;
    if (!awake) begin
      active_nxt = pss_pkg::PSS_BIT_RST;
    end else if (cap_any) begin
      addr_hi_nxt = addr_in[ADDR_W-1:BW];
      start_nxt   = addr_in[BW-1:0];
      step_nxt    = pss_pkg::PSS_STEP_RST;
      active_nxt  = 1'h1;
      mask_nxt    = !active_r;
    end else if (strobe_seen) begin
      active_nxt = pss_pkg::PSS_BIT_RST;
    end else if (active_r && !ctl_in.burst_step_n) begin
      step_nxt = BW'(step_r + 2'h1);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      addr_hi_r <= '0;
      start_r   <= pss_pkg::PSS_STEP_RST;
      step_r    <= pss_pkg::PSS_STEP_RST;
      active_r  <= pss_pkg::PSS_BIT_RST;
      mask_r    <= pss_pkg::PSS_BIT_RST;
    end else begin
      addr_hi_r <= addr_hi_nxt;
      start_r   <= start_nxt;
      step_r    <= step_nxt;
      active_r  <= active_nxt;
      mask_r    <= mask_nxt;
    end
  end

  // ==========================================================
  // Write path: pins registered, array written next edge
  logic [WW-1:0]     wdata_r, wdata_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic              wpend_r, wpend_nxt;

  always_comb begin
    wdata_nxt = {parity_io_in, data_in};
    waddr_nxt = cur_addr;
    wpend_nxt = awake && active_r && !cap_any && !ctl_in.write_n;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wdata_r <= '0;
      waddr_r <= '0;
      wpend_r <= pss_pkg::PSS_BIT_RST;
    end else begin
      wdata_r <= wdata_nxt;
      waddr_r <= waddr_nxt;
      wpend_r <= wpend_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (wpend_r) begin
      mem[waddr_r] <= wdata_r;
    end
  end

  // ==========================================================
  // Read path: output register and drive enable
  logic [WW-1:0] q_r, q_nxt;
  logic          drive_n_r, drive_n_nxt;
  logic          rd_now;

  always_comb begin
    rd_now      = awake && active_r && ctl_in.write_n;
    q_nxt       = rd_now ? mem[cur_addr] : q_r;
    drive_n_nxt = !(rd_now && !oe_s2_r && !mask_r);
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      q_r       <= '0;
      drive_n_r <= pss_pkg::PSS_OE_N_RST;
    end else begin
      q_r       <= q_nxt;
      drive_n_r <= drive_n_nxt;
    end
  end

  // Pins straight from registers
  always_comb begin
    data_out      = q_r[DATA_W-1:0];
    parity_io_out = q_r[WW-1:DATA_W];
    data_oe_n_out = drive_n_r;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_cap_from_idle;
    cap_any && !active_r;
  endsequence

  sequence s_read_next;
    ##1 (ctl_in.write_n && !strobe_seen && awake);
  endsequence

  a_proc_capture: assert property (
    cap_p |=> addr_hi_r == $past(addr_in[ADDR_W-1:BW]) &&
              start_r == $past(addr_in[BW-1:0]) && step_r == 2'h0)
    else $error("processor strobe did not capture address");

  a_ctrl_capture: assert property (
    cap_c |=> start_r == $past(addr_in[BW-1:0]) && active_r)
    else $error("controller strobe did not load counter");

  a_proc_priority: assert property (
    (awake && sel_all && !ctl_in.proc_strobe_n && !ctl_in.ctrl_strobe_n)
      |-> cap_p && !cap_c)
    else $error("controller strobe acted beside processor strobe");

  a_primary_gate: assert property (
    (ctl_in.primary_select_n && ctl_in.ctrl_strobe_n)
      |=> $stable(addr_hi_r) && $stable(start_r))
    else $error("address changed while primary select high");

  a_select_gate: assert property (
    (strobe_seen && !sel_all && awake) |=> !active_r)
    else $error("unselected strobe left device active");

  a_burst_step: assert property (
    (active_r && awake && !strobe_seen && !ctl_in.burst_step_n)
      |=> step_r == BW'($past(step_r) + 2'h1))
    else $error("burst counter did not step");

  a_sleep_sync: assert property (
    $rose(sleep_s2_r) |-> $past(sleep_request_in, 2) ##1 drive_n_r)
    else $error("sleep not synchronised or output still driven");

  a_oe_float: assert property (
    oe_s2_r |=> data_oe_n_out)
    else $error("data driven while output enable high");

  a_first_mask: assert property (
    s_cap_from_idle |=> data_oe_n_out [*2])
    else $error("output enable not masked after deselect");

  a_read_pipe: assert property (
    (s_cap_from_idle ##0 !wpend_r) ##0 s_read_next
      |=> q_r == mem[$past(cur_addr)])
    else $error("read data not from captured address");

  a_write_reg: assert property (
    wpend_r |-> wdata_r == $past({parity_io_in, data_in}))
    else $error("write data not registered at edge");

endmodule

// *** tb/pss_bus_partner.sv ***
// Bus partner: resolves the shared data and parity wires
`timescale 1ns/1ns
module pss_bus_partner (
  input  wire logic        clk_sys_in,
  input  wire logic [35:0] dev_word_in,
  input  wire logic        dev_oe_n_in,
  input  wire logic [35:0] host_word_in,
  input  wire logic        host_en_in,
  output logic      [35:0] wire_out
);
  logic [35:0] last_r = 36'h0;
  // Released wire flips each cycle
  always_comb begin
    if (!dev_oe_n_in) begin
      wire_out = dev_word_in;
    end else if (host_en_in) begin
      wire_out = host_word_in;
    end else begin
      wire_out = ~last_r;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    last_r <= wire_out;
  end
endmodule

// *** tb/pipelined_sram_strobe_and_data_port_tb_top.sv ***
// Testbench: bursts, deselect, sleep checked against a word model
`timescale 1ns/1ns
module pipelined_sram_strobe_and_data_port_tb_top;
  logic              clk = 1'h0;
  logic              rst_n = 1'h0;
  logic              order = 1'h0;
  logic              oe_n = 1'h1;
  logic              sleep = 1'h0; // Low until the sleep phase raises it
  logic              host_en = 1'h0;
  logic [17:0]       addr = 18'h0;
  logic [17:0]       a;
  logic [35:0]       host_w = 36'h0;
  logic [35:0]       wire_w;
  logic [31:0]       dout;
  logic [3:0]        pout;
  logic              doe_n;
  pss_pkg::pss_ctl_t ctl = 7'h6b;
  logic [35:0]       mem [int];
  int                failures = 0;
  int                checked = 0;

  pss_sram_port i_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .addr_in(addr),
    .ctl_in(ctl), .burst_order_in(order), .output_enable_n_in(oe_n),
    .sleep_request_in(sleep), .data_in(wire_w[35:4]),
    .parity_io_in(wire_w[3:0]), .data_out(dout), .parity_io_out(pout),
    .data_oe_n_out(doe_n));
  pss_bus_partner i_bus (.clk_sys_in(clk), .dev_word_in({dout, pout}),
    .dev_oe_n_in(doe_n), .host_word_in(host_w), .host_en_in(host_en),
    .wire_out(wire_w));

  // ==========================================================
  // Helpers
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [17:0] baddr(logic [17:0] b, int k);
    logic [1:0] lo;
    lo = order ? (b[1:0] ^ k[1:0]) : 2'(b[1:0] + k[1:0]);
    return {b[17:2], lo};
  endfunction
  task automatic step(input logic [6:0] c, input logic [17:0] b);
    @(posedge clk);
    ctl <= c;
    addr <= b;
  endtask
  task automatic wr_burst(input logic [17:0] b);
    logic [35:0] d;
    int s;
    s = $urandom_range(2);
    step({s == 1, s == 0, 5'h0b}, b);
    for (int k = 0; k < 4; k++) begin
      d = {$urandom, 4'($urandom)};
      step((k == 3) ? 7'h6a : 7'h68, 18'($urandom));
      host_w <= d;
      host_en <= 1'h1;
      if (!sleep) mem[baddr(b, k)] = d;
    end
    step(7'h6b, 18'($urandom));
    host_en <= 1'h0;
  endtask
  task automatic rd_burst(input logic [17:0] b);
    step(7'h23, 18'($urandom));
    oe_n <= 1'h0;
    step(7'h4b, b);
    for (int k = 0; k < 5; k++) begin
      step((k == 1) ? 7'h39 : ((k > 2) ? 7'h6b : 7'h69), 18'($urandom));
      @(negedge clk);
      if (k > 0) check({dout, pout}, mem[baddr(b, k - 1)]);
      if (k > 0) check(36'(doe_n), 36'(k == 1));
    end
    step(7'h6b, 18'($urandom));
    oe_n <= 1'h1;
    repeat (3) step(7'h6b, 18'($urandom));
    @(negedge clk);
    check(36'(doe_n), 36'h1);
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and sequence
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    failures++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(70));
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    check(36'(doe_n), 36'h1);
    for (int i = 0; i < 6; i++) begin
      a = 18'($urandom);
      @(posedge clk);
      order <= i[0];
      wr_burst(a);
      rd_burst(a);
    end
    // Write while asleep is dropped, contents kept
    @(posedge clk);
    sleep <= 1'h1;
    repeat (3) step(7'h6b, a);
    wr_burst(a);
    sleep <= 1'h0;
    repeat (3) step(7'h6b, a);
    rd_burst(a);
    tally_and_finish;
  end
endmodule
